/* gpb_pkg.sv */
/*
 * constants of the general purpose pad bank: register map, reset values,
 * control bit positions and bus answer codes.
 * assumes a 32-bit word-aligned register bus.
 */
package gpb_pkg;
    // ==========================================================
    // geometry
    localparam int          GPB_PINS      = 17;
    localparam int          GPB_AW        = 8;
    localparam int          GPB_SYNC_LEN  = 3;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0]  OFS_OUT_DATA  = 8'h00;
    localparam logic [7:0]  OFS_OUT_EN    = 8'h04;
    localparam logic [7:0]  OFS_FUNC_SEL  = 8'h08;
    localparam logic [7:0]  OFS_PULL_UP   = 8'h0C;
    localparam logic [7:0]  OFS_PULL_DN   = 8'h10;
    localparam logic [7:0]  OFS_IN_LEVEL  = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h18;
    localparam logic [7:0]  OFS_IRQ_LEVEL = 8'h1C;
    localparam logic [7:0]  OFS_IRQ_POL   = 8'h20;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h24;
    localparam logic [7:0]  OFS_HOLD      = 8'h28;
    localparam logic [7:0]  OFS_CTRL      = 8'h2C;

    // ==========================================================
    // control register fields
    localparam int          CTRL_PWRDN_BIT = 0;
    localparam int          CTRL_KEEP_BIT  = 1;
    localparam int          CTRL_BITS      = 2;

    // ==========================================================
    // reset values
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    localparam logic [1:0]  RST_CTRL      = 2'h0;

    // ==========================================================
    // bus answers
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

/* gpb_sync.sv */
/*
 * three-stage pin synchroniser with agreement filter.
 * assumes asynchronous pin levels; the output follows once the second
 * and third stages agree.
 */
`timescale 1ns/1ps
module gpb_sync #(
    parameter int WIDTH = 17
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // level in and filtered level out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_d;

    // ==========================================================
    // accept a new level only once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
        end
    end

    // stage one feeds only stage two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else begin
            s1_q    <= async_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end
endmodule

/* gpb_irq_det.sv */
/*
 * per-pin interrupt condition detector, edge or level, either polarity.
 * assumes synchronised input levels on the same clock.
 */
`timescale 1ns/1ps
module gpb_irq_det #(
    parameter int WIDTH = 17
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // level and per-pin configuration
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] lvl_mode,
    input  wire logic [WIDTH-1:0] pol_high,
    // per-pin condition: one cycle on an edge, held while active in level mode
    output logic      [WIDTH-1:0] event_hit
);
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;
    logic [2:0]       prime_q;
    logic [2:0]       prime_d;
    logic             primed;

    // ==========================================================
    // level mode hits while active; edge mode on entering the active level
    always_comb begin
        prev_d   = level;
        // wait out the synchroniser so a high pin gives no false edge
        primed   = (prime_q == 3'h6);
        prime_d  = primed ? prime_q : prime_q + 3'h1;
        for (int i = 0; i < WIDTH; i++) begin
            if (lvl_mode[i]) begin
                event_hit[i] = (level[i] == pol_high[i]);
            end else begin
                event_hit[i] = primed && (level[i] == pol_high[i])
                               && (prev_q[i] != level[i]);
            end
        end
    end

    // early samples after reset only prime the edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q   <= '0;
            prime_q  <= 3'h0;
        end else begin
            prev_q   <= prev_d;
            prime_q  <= prime_d;
        end
    end
endmodule

/* gpb_bank.sv */
/*
 * general purpose pad bank: seventeen pins with alternate function
 * routing, pulls, input capture, interrupts and hold, behind AXI4-Lite.
 * assumes one clock; pads resolved outside from out, oe, pulls and keeper.
 */
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
// Notes on behaviour
// - seventeen pins, each assignable to a function by register writes.
// - each pin can pull up, pull down or float with no pull.
// - the pin level is captured into a register software can read.
// - each pin may raise an interrupt, on an edge or on a level.
// - pads are non-inverting with input path and tristate output drive.
// - each pin is routed to its own logic or to an alternate peripheral.
// - software can order each pin to hold its present pad state; power-down still forces a held output enable low.
// - on power-down every output enable can be forced and held low.
// - with the keeper on and no driver, the pad keeps its last level.
`timescale 1ns/1ps
module gpb_bank
    import gpb_pkg::*;
#(
    parameter int N_PINS = gpb_pkg::GPB_PINS
) (
    // clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // axi4-lite write address and data
    input  wire logic [gpb_pkg::GPB_AW-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    // axi4-lite write response
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // axi4-lite read
    input  wire logic [gpb_pkg::GPB_AW-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // pads
    input  wire logic [N_PINS-1:0]          pad_in,
    output logic      [N_PINS-1:0]          pad_out,
    output logic      [N_PINS-1:0]          pad_oe,
    output logic      [N_PINS-1:0]          pad_pull_up,
    output logic      [N_PINS-1:0]          pad_pull_dn,
    output logic      [N_PINS-1:0]          pad_keep,
    // alternate peripheral side
    input  wire logic [N_PINS-1:0]          alt_out,
    input  wire logic [N_PINS-1:0]          alt_oe,
    output logic      [N_PINS-1:0]          alt_in,
    // interrupt
    output logic                            irq
);
    // ==========================================================
    // elaboration check
    if (N_PINS < 1 || N_PINS > 32) begin : g_chk
        $error("gpb_bank: N_PINS must be 1 to 32");
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) res[b*8 +: 8] = new_w[b*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic is_mapped(input logic [GPB_AW-1:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_CTRL);
    endfunction

    function automatic logic [31:0] widen(input logic [N_PINS-1:0] v);
        logic [31:0] res;
        res = '0;
        res[N_PINS-1:0] = v;
        return res;
    endfunction

    // ==========================================================
    // state
    logic [GPB_AW-1:0] aw_addr_q, aw_addr_d;
    logic              aw_full_q, aw_full_d;
    logic [31:0]       w_data_q, w_data_d;
    logic [3:0]        w_strb_q, w_strb_d;
    logic              w_full_q, w_full_d;
    logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0]        bresp_d, rresp_d;
    logic [31:0]       rdata_d;

    logic [N_PINS-1:0] out_q, out_d, oe_q, oe_d, func_q, func_d;
    logic [N_PINS-1:0] pu_q, pu_d, pd_q, pd_d, in_q, in_d;
    logic [N_PINS-1:0] mask_q, mask_d, lvl_q, lvl_d, pol_q, pol_d;
    logic [N_PINS-1:0] stat_q, stat_d, hold_q, hold_d;
    logic [CTRL_BITS-1:0] ctrl_q, ctrl_d;
    logic [N_PINS-1:0] pad_out_d, pad_oe_d, pad_pu_d, pad_pd_d, pad_keep_d;
    logic              irq_d;

    logic [N_PINS-1:0] pin_level;
    logic [N_PINS-1:0] event_hit;
    logic              do_wr, ar_take, stat_rd;
    logic [31:0]       wr_word;

    // ==========================================================
    // submodules
    gpb_sync #(.WIDTH(N_PINS)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pad_in),
        .level_q  (pin_level)
    );

    gpb_irq_det #(.WIDTH(N_PINS)) u_det (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .level     (pin_level),
        .lvl_mode  (lvl_q),
        .pol_high  (pol_q),
        .event_hit (event_hit)
    );

    // ==========================================================
    // bus handshakes: one write and one read outstanding
    always_comb begin
        aw_addr_d = aw_addr_q;
        aw_full_d = aw_full_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        w_full_d  = w_full_q;
        bvalid_d  = bvalid;
        bresp_d   = bresp;
        rvalid_d  = rvalid;
        rresp_d   = rresp;
        rdata_d   = rdata;
        if (awvalid && awready) begin
            aw_addr_d = awaddr;
            aw_full_d = 1'b1;
        end
        if (wvalid && wready) begin
            w_data_d = wdata;
            w_strb_d = wstrb;
            w_full_d = 1'b1;
        end
        do_wr = aw_full_q && w_full_q && !bvalid;
        if (bvalid && bready) bvalid_d = 1'b0;
        if (do_wr) begin
            bvalid_d  = 1'b1;
            bresp_d   = is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
        end
        ar_take = arvalid && arready;
        stat_rd = ar_take && (araddr == OFS_IRQ_STAT);
        if (rvalid && rready) rvalid_d = 1'b0;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rresp_d  = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                OFS_OUT_DATA:  rdata_d = widen(out_q);
                OFS_OUT_EN:    rdata_d = widen(oe_q);
                OFS_FUNC_SEL:  rdata_d = widen(func_q);
                OFS_PULL_UP:   rdata_d = widen(pu_q);
                OFS_PULL_DN:   rdata_d = widen(pd_q);
                OFS_IN_LEVEL:  rdata_d = widen(in_q);
                OFS_IRQ_MASK:  rdata_d = widen(mask_q);
                OFS_IRQ_LEVEL: rdata_d = widen(lvl_q);
                OFS_IRQ_POL:   rdata_d = widen(pol_q);
                OFS_IRQ_STAT:  rdata_d = widen(stat_q);
                OFS_HOLD:      rdata_d = widen(hold_q);
                OFS_CTRL:      rdata_d = {{(32-CTRL_BITS){1'b0}}, ctrl_q};
                default:       rdata_d = RST_WORD;
            endcase
        end
        awready_d = !aw_full_d && !bvalid_d;
        wready_d  = !w_full_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // ==========================================================
    // register file writes and sticky status
    always_comb begin
        out_d  = out_q;
        oe_d   = oe_q;
        func_d = func_q;
        pu_d   = pu_q;
        pd_d   = pd_q;
        mask_d = mask_q;
        lvl_d  = lvl_q;
        pol_d  = pol_q;
        hold_d = hold_q;
        ctrl_d = ctrl_q;
        wr_word = RST_WORD;
        case (aw_addr_q)
            OFS_OUT_DATA:  wr_word = widen(out_q);
            OFS_OUT_EN:    wr_word = widen(oe_q);
            OFS_FUNC_SEL:  wr_word = widen(func_q);
            OFS_PULL_UP:   wr_word = widen(pu_q);
            OFS_PULL_DN:   wr_word = widen(pd_q);
            OFS_IRQ_MASK:  wr_word = widen(mask_q);
            OFS_IRQ_LEVEL: wr_word = widen(lvl_q);
            OFS_IRQ_POL:   wr_word = widen(pol_q);
            OFS_HOLD:      wr_word = widen(hold_q);
            OFS_CTRL:      wr_word = {{(32-CTRL_BITS){1'b0}}, ctrl_q};
            default:       wr_word = RST_WORD;
        endcase
        // byte lanes without a strobe keep their old contents
        wr_word = merge_strb(wr_word, w_data_q, w_strb_q);
        if (do_wr) begin
            case (aw_addr_q)
                OFS_OUT_DATA:  out_d  = wr_word[N_PINS-1:0];
                OFS_OUT_EN:    oe_d   = wr_word[N_PINS-1:0];
                OFS_FUNC_SEL:  func_d = wr_word[N_PINS-1:0];
                OFS_PULL_UP:   pu_d   = wr_word[N_PINS-1:0];
                OFS_PULL_DN:   pd_d   = wr_word[N_PINS-1:0];
                OFS_IRQ_MASK:  mask_d = wr_word[N_PINS-1:0];
                OFS_IRQ_LEVEL: lvl_d  = wr_word[N_PINS-1:0];
                OFS_IRQ_POL:   pol_d  = wr_word[N_PINS-1:0];
                OFS_HOLD:      hold_d = wr_word[N_PINS-1:0];
                OFS_CTRL:      ctrl_d = wr_word[CTRL_BITS-1:0];
                default:       ctrl_d = ctrl_q;
            endcase
        end
        in_d   = pin_level;
        // a read clears, but an event in the same cycle wins
        stat_d = (stat_rd ? '0 : stat_q) | event_hit;
        irq_d  = |(stat_d & mask_d);
    end

    // ==========================================================
    // pad drive: routing, hold, power-down and keeper
    always_comb begin
        for (int i = 0; i < N_PINS; i++) begin
            // non-inverting route from own logic or peripheral
            pad_out_d[i] = func_q[i] ? alt_out[i] : out_q[i];
            pad_oe_d[i]  = func_q[i] ? alt_oe[i]  : oe_q[i];
            // pull-up has priority when both pulls are set
            pad_pu_d[i]  = pu_q[i];
            pad_pd_d[i]  = pd_q[i] && !pu_q[i];
            if (hold_q[i]) begin
                pad_out_d[i] = pad_out[i];
                pad_oe_d[i]  = pad_oe[i];
                pad_pu_d[i]  = pad_pull_up[i];
                pad_pd_d[i]  = pad_pull_dn[i];
            end
            if (ctrl_q[CTRL_PWRDN_BIT]) pad_oe_d[i] = 1'b0;
            // undriven pad: keeper latches the last level seen
            pad_keep_d[i] = ctrl_q[CTRL_KEEP_BIT] && !pad_oe_d[i];
            if (pad_keep_d[i]) pad_out_d[i] = pin_level[i];
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q   <= '0;
            aw_full_q   <= 1'b0;
            w_data_q    <= RST_WORD;
            w_strb_q    <= 4'h0;
            w_full_q    <= 1'b0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= RESP_OKAY;
            arready     <= 1'b0;
            rvalid      <= 1'b0;
            rresp       <= RESP_OKAY;
            rdata       <= RST_WORD;
            out_q       <= '0;
            oe_q        <= '0;
            func_q      <= '0;
            pu_q        <= '0;
            pd_q        <= '0;
            in_q        <= '0;
            mask_q      <= '0;
            lvl_q       <= '0;
            pol_q       <= '0;
            stat_q      <= '0;
            hold_q      <= '0;
            ctrl_q      <= RST_CTRL;
            pad_out     <= '0;
            pad_oe      <= '0;
            pad_pull_up <= '0;
            pad_pull_dn <= '0;
            pad_keep    <= '0;
            alt_in      <= '0;
            irq         <= 1'b0;
        end else begin
            aw_addr_q   <= aw_addr_d;
            aw_full_q   <= aw_full_d;
            w_data_q    <= w_data_d;
            w_strb_q    <= w_strb_d;
            w_full_q    <= w_full_d;
            awready     <= awready_d;
            wready      <= wready_d;
            bvalid      <= bvalid_d;
            bresp       <= bresp_d;
            arready     <= arready_d;
            rvalid      <= rvalid_d;
            rresp       <= rresp_d;
            rdata       <= rdata_d;
            out_q       <= out_d;
            oe_q        <= oe_d;
            func_q      <= func_d;
            pu_q        <= pu_d;
            pd_q        <= pd_d;
            in_q        <= in_d;
            mask_q      <= mask_d;
            lvl_q       <= lvl_d;
            pol_q       <= pol_d;
            stat_q      <= stat_d;
            hold_q      <= hold_d;
            ctrl_q      <= ctrl_d;
            pad_out     <= pad_out_d;
            pad_oe      <= pad_oe_d;
            pad_pull_up <= pad_pu_d;
            pad_pull_dn <= pad_pd_d;
            pad_keep    <= pad_keep_d;
            alt_in      <= pin_level;
            irq         <= irq_d;
        end
    end
endmodule

/* gpb_bank_properties.sv */
/*
 * checker of the pad bank: bus timing, pulls, keeper, input, interrupt.
 * assumes it is bound onto the bank's ports.
 */
`timescale 1ns/1ps
module gpb_bank_chk #(
    parameter int N_PINS = 17
) (
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // bus handshakes
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic              wvalid,
    input wire logic              wready,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic [1:0]        bresp,
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic              rvalid,
    input wire logic              rready,
    input wire logic [31:0]       rdata,
    // pads, peripheral side and interrupt
    input wire logic [N_PINS-1:0] pad_in,
    input wire logic [N_PINS-1:0] pad_oe,
    input wire logic [N_PINS-1:0] pad_pull_up,
    input wire logic [N_PINS-1:0] pad_pull_dn,
    input wire logic [N_PINS-1:0] pad_keep,
    input wire logic [N_PINS-1:0] alt_in,
    input wire logic              irq
);
    // ==========================================================
    // common clock and reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // steps of a transfer
    sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
    sequence s_rd_taken; arvalid && arready; endsequence

    property p_wr_lat; s_wr_taken |-> ##[1:2] bvalid; endproperty
    property p_rd_lat; s_rd_taken |=> rvalid; endproperty
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    property p_hi_bits; rvalid |-> rdata[31:N_PINS] == '0; endproperty
    property p_pull; (pad_pull_up & pad_pull_dn) == '0; endproperty
    property p_keep; (pad_keep & pad_oe) == '0; endproperty
    property p_sync; $stable(pad_in) [*7] |-> alt_in == pad_in; endproperty
    property p_irq_fall;
        $fell(irq) |-> rvalid || $past(rvalid) || bvalid
            || $past(awvalid && awready);
    endproperty

    a_wr_lat: assert property (p_wr_lat) else $error("bvalid late");
    a_rd_lat: assert property (p_rd_lat) else $error("rvalid late");
    a_b_hold: assert property (p_b_hold) else $error("bvalid drop");
    a_r_hold: assert property (p_r_hold) else $error("rvalid drop");
    a_hi_bits: assert property (p_hi_bits) else $error("high bits");
    a_pull: assert property (p_pull) else $error("both pulls on");
    a_keep: assert property (p_keep) else $error("keeper on drive");
    a_sync: assert property (p_sync) else $error("alt_in stale");
    a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
endmodule

/* gpb_pad_model.sv */
/*
 * circuitry at the pads: driver, pulls, keeper, wandering float.
 * assumes the bench drives ext_en and ext_val.
 */
`timescale 1ns/1ps
module gpb_pad_model #(
    parameter int N = 17
) (
    // clock
    input  wire logic         aclk,
    // bank pad outputs
    input  wire logic [N-1:0] pad_out,
    input  wire logic [N-1:0] pad_oe,
    input  wire logic [N-1:0] pad_pull_up,
    input  wire logic [N-1:0] pad_pull_dn,
    input  wire logic [N-1:0] pad_keep,
    // external driver and resolved level
    input  wire logic [N-1:0] ext_en,
    input  wire logic [N-1:0] ext_val,
    output logic      [N-1:0] pad_lvl
);
    logic flip_q = 1'b0;

    // undriven, unpulled pads without the keeper never settle
    always @(posedge aclk) flip_q <= ~flip_q;

    // strongest source wins, pin by pin
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (pad_oe[i]) pad_lvl[i] = pad_out[i];
            else if (ext_en[i]) pad_lvl[i] = ext_val[i];
            else if (pad_keep[i]) pad_lvl[i] = pad_out[i];
            else if (pad_pull_up[i]) pad_lvl[i] = 1'b1;
            else if (pad_pull_dn[i]) pad_lvl[i] = 1'b0;
            else pad_lvl[i] = flip_q;
        end
    end
endmodule

/* gpb_bank_tb.sv */
/*
 * self-checking bench of the pad bank over AXI4-Lite.
 * assumes all block files are compiled.
 */
`timescale 1ns/1ps
module gpb_bank_tb;
    import gpb_pkg::*;
    localparam logic [16:0] ALL = 17'h1_FFFF;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [16:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_dn;
    logic [16:0] pad_keep, alt_out, alt_oe, alt_in, ext_en, ext_val;
    int          n_mismatch = 0, tests_run = 0, cyc = 0;

    gpb_bank u_gpb_bank (.*, .wstrb(4'hf));
    gpb_pad_model u_gpb_pad_model (.*, .pad_lvl(pad_in));

    // ==========================================================
    // clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test;
        end
    end

    // ==========================================================
    // shared tasks
    task automatic end_of_test;
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk("bresp", 32'(r), 32'(bresp));
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF,
                      input logic [1:0] r = RESP_OKAY);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk("rdata", e & m, rdata & m);
        chk("rresp", 32'(r), 32'(rresp));
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < 12; i++) rd(8'(i * 4), 32'h0);
        rd(8'h30, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        rd(8'h05, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(8'h30, 32'hFFFF_FFFF, RESP_SLVERR);
    endtask
    task automatic t_out;
        ext_en <= 17'h0;
        wr(OFS_OUT_DATA, 32'h0001_A5C3);
        wr(OFS_OUT_EN, 32'h0001_FFFF);
        repeat (6) @(posedge aclk);
        chk("pad_oe", 32'h0001_FFFF, 32'(pad_oe));
        chk("pad", 32'h0001_A5C3, 32'(pad_in));
        chk("alt_in", 32'h0001_A5C3, 32'(alt_in));
        wr(OFS_IN_LEVEL, 32'h0);
        rd(OFS_IN_LEVEL, 32'h0001_A5C3);
    endtask
    task automatic t_pull;
        wr(OFS_OUT_EN, 32'h0);
        wr(OFS_PULL_UP, 32'h0000_00FF);
        wr(OFS_PULL_DN, 32'h0000_0F0F);
        repeat (6) @(posedge aclk);
        chk("pull_up", 32'h0000_00FF, 32'(pad_pull_up));
        chk("pull_dn", 32'h0000_0F00, 32'(pad_pull_dn));
        rd(OFS_IN_LEVEL, 32'h0000_00FF, 32'h0000_0FFF);
    endtask
    task automatic t_alt;
        wr(OFS_FUNC_SEL, 32'h0001_FFFF);
        alt_out <= 17'h0_3C3C;
        alt_oe  <= 17'h1_FF00;
        repeat (8) @(posedge aclk);
        chk("alt_oe", 32'h0001_FF00, 32'(pad_oe));
        chk("alt_pad", 32'h0000_3CFF, 32'(pad_in));
        chk("alt_in", 32'h0000_3CFF, 32'(alt_in));
        wr(OFS_FUNC_SEL, 32'h0);
        repeat (2) @(posedge aclk);
        chk("gpio_oe", 32'h0, 32'(pad_oe));
        alt_oe <= 17'h0;
    endtask
    task automatic t_irq;
        ext_en  <= ALL;
        ext_val <= 17'h0;
        repeat (8) @(posedge aclk);
        rd(OFS_IRQ_STAT, 32'h0, 32'h0);
        wr(OFS_IRQ_POL, 32'h1);
        wr(OFS_IRQ_MASK, 32'h1);
        chk("irq_idle", 32'h0, 32'(irq));
        ext_val <= 17'h1;
        repeat (8) @(posedge aclk);
        chk("irq_edge", 32'h1, 32'(irq));
        rd(OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq_clr", 32'h0, 32'(irq));
        rd(OFS_IRQ_STAT, 32'h0);
        wr(OFS_IRQ_LEVEL, 32'h2);
        wr(OFS_IRQ_MASK, 32'h2);
        repeat (4) @(posedge aclk);
        chk("irq_lvl", 32'h1, 32'(irq));
        rd(OFS_IRQ_STAT, 32'h2);
        rd(OFS_IRQ_STAT, 32'h2);
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq_mask", 32'h0, 32'(irq));
        wr(OFS_IRQ_LEVEL, 32'h0);
    endtask
    task automatic t_hold;
        ext_en <= 17'h0;
        wr(OFS_OUT_DATA, 32'h0000_1234);
        wr(OFS_OUT_EN, 32'h0001_FFFF);
        wr(OFS_HOLD, 32'h0001_FFFF);
        wr(OFS_OUT_DATA, 32'h0001_4321);
        wr(OFS_OUT_EN, 32'h0);
        repeat (3) @(posedge aclk);
        chk("hold_out", 32'h0000_1234, 32'(pad_out));
        chk("hold_oe", 32'h0001_FFFF, 32'(pad_oe));
        wr(OFS_CTRL, 32'h1);
        repeat (3) @(posedge aclk);
        chk("pd_oe", 32'h0, 32'(pad_oe));
        wr(OFS_CTRL, 32'h2);
        wr(OFS_HOLD, 32'h0);
        ext_en  <= ALL;
        ext_val <= 17'h0_5555;
        repeat (8) @(posedge aclk);
        ext_en <= 17'h0;
        repeat (8) @(posedge aclk);
        chk("keep", 32'h0001_FFFF, 32'(pad_keep));
        chk("kept", 32'h0000_5555, 32'(pad_in));
        rd(OFS_IN_LEVEL, 32'h0000_5555);
    endtask

    // ==========================================================
    // main sequence, with a second reset after the last scenario
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        {alt_out, alt_oe, ext_val} = '0;
        ext_en = ALL;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset;
        t_out;
        t_pull;
        t_alt;
        t_irq;
        t_hold;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(OFS_CTRL, 32'h0);
        chk("keep_rst", 32'h0, 32'(pad_keep));
        end_of_test;
    end
endmodule

bind gpb_bank gpb_bank_chk #(.N_PINS(N_PINS)) u_gpb_bank_chk (.*);
